// File: design/cwr_responder.sv
// coil write checking, execution and exception answer builder
// Summary of operation
// - station address 0 broadcast of coil write is ignored, never answered
// - query: fc 15, start hi/lo, count hi/lo, byte count, data, check
// - coil start 0..15 accepted; 16 or more gives improper address
// - byte count 0 or 3 and above gives improper data
// - coil count 1..16 accepted; 0 or 17 and above gives improper address
// - start plus count running past coil range is no error
// - count nine or more with byte count one or less is improper data
// - count eight or fewer with byte count two is accepted
// - data lsb first ascending coils; bits past count ignored
// - reserved run word bits always read zero
// - good write answered with address, fc, start and count echo
// - improper query not executed; answer address, exception fc, subcode
// - error answer carries the query station address
// - exception fc is fc plus 80h, unchanged when above 80h
// - unsupported fc gives subcode 1, highest priority
// - bad address or data count gives subcode 2, priority 2
// - unused codes after the first raise no error
// - start plus count past code range raises no error
// - diagnostics with nonzero subfunction gives improper address
// - write data out of range gives subcode 3, priority 3
// - no write right or locked target gives subcode 7
// - order of 3 and 7 depends on the cause of 7
// - each error answer stores its subcode in the error code
// - character gap of 33 bits closes or discards the frame
`timescale 1ns/1ns
module cwr_responder (
  input wire logic ref_clk,
  input wire logic rst,
  input wire cwr_pkg::cwr_rx_s rx_in,
  input wire logic bit_tick,
  input wire logic crc_ok,
  input wire logic [7:0] own_addr,
  input wire logic link_no_write,
  input wire logic run_locked,
  input wire logic tx_ready,
  output cwr_pkg::cwr_tx_s tx_q,
  output logic tx_valid_q,
  output logic [15:0] run_command_word_q,
  output logic [7:0] last_link_error_code_q
);
  import cwr_pkg::*;

  cwr_state_e st_q;
  cwr_state_e st_d;
  logic [7:0] buf_q [BUF_DEPTH];
  logic [3:0] cnt_q;
  logic [5:0] gap_q;
  logic [3:0] idx_q;
  logic [3:0] len_q;

  // query fields
  wire logic [7:0] q_addr = buf_q[0];
  wire logic [7:0] q_fc = buf_q[1];
  wire logic [15:0] q_start = {buf_q[2], buf_q[3]};
  wire logic [15:0] q_qty = {buf_q[4], buf_q[5]};
  wire logic [7:0] q_bc = buf_q[6];
  wire logic [15:0] q_data = {(q_bc == BC_MAX) ? buf_q[8] : 8'h00, buf_q[7]};

  // frame closes on a long gap
  wire logic gap_end = (cnt_q != 4'h0) && (gap_q >= GAP_BITS);
  wire logic frame_long = cnt_q >= MIN_FRAME;
  wire logic for_us = crc_ok && frame_long && (q_addr == own_addr) &&
    (q_addr != BCAST_ADDR);

  wire logic fc_known = (q_fc == FC_READ_COIL) || (q_fc == FC_READ_HOLD) ||
    (q_fc == FC_FORCE_ONE) || (q_fc == FC_PRESET_ONE) ||
    (q_fc == FC_DIAG) || (q_fc == FC_FORCE_MULTI) ||
    (q_fc == FC_PRESET_MULTI);
  wire logic is_multi = q_fc == FC_FORCE_MULTI;
  wire logic diag_bad = (q_fc == FC_DIAG) && ({buf_q[2], buf_q[3]} != 16'h0);
  wire logic addr_bad = (q_start >= COIL_LIMIT) || (q_qty == 16'h0) ||
    (q_qty > QTY_MAX);
  wire logic len_bad = {4'h0, cnt_q} != (FRAME_FIXED + q_bc);
  wire logic bc_bad = (q_bc == 8'h00) || (q_bc > BC_MAX) ||
    ((q_qty >= QTY_WIDE) && (q_bc < BC_MAX)) || len_bad;
  wire logic ours = !fc_known || diag_bad || is_multi;

  logic [7:0] sub_w;
  always_comb begin
    sub_w = SUB_NONE;
    if (!fc_known) begin
      sub_w = SUB_FC;
    end else if (diag_bad) begin
      sub_w = SUB_ADDR;
    end else if (addr_bad) begin
      sub_w = SUB_ADDR;
    end else if (link_no_write) begin
      sub_w = SUB_NAK;
    end else if (bc_bad) begin
      sub_w = SUB_DATA;
    end else if (run_locked) begin
      sub_w = SUB_NAK;
    end
  end

  wire logic respond = for_us && ours;
  wire logic is_err = sub_w != SUB_NONE;
  wire logic [7:0] exc_w = (q_fc > EXC_FLAG) ? q_fc : q_fc + EXC_FLAG;

  logic [15:0] word_w;
  logic [4:0] rel;
  always_comb begin
    word_w = run_command_word_q;
    rel = 5'h00;
    for (int i = 0; i < 16; i++) begin
      rel = 5'(i) - {1'b0, q_start[3:0]};
      if ((5'(i) >= {1'b0, q_start[3:0]}) && ({11'h000, rel} < q_qty)) begin
        word_w[i] = q_data[rel[3:0]];
      end
    end
    word_w = word_w & ~RUN_RSVD;
  end

  wire logic tx_step = tx_ready || !tx_valid_q;
  wire logic tx_more = idx_q < len_q;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_RX: begin
        if (gap_end) begin
          st_d = ST_EVAL;
        end
      end
      ST_EVAL: begin
        st_d = respond ? ST_TX : ST_RX;
      end
      ST_TX: begin
        if (tx_step && !tx_more) begin
          st_d = ST_RX;
        end
      end
      default: st_d = ST_RX;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= ST_RX;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || st_q != ST_RX || rx_in.valid) begin
      gap_q <= 6'h00;
    end else if (bit_tick && gap_q < GAP_BITS) begin
      gap_q <= gap_q + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || st_q == ST_EVAL) begin
      cnt_q <= 4'h0;
    end else if (st_q == ST_RX && rx_in.valid && cnt_q < BUF_MAX) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (st_q == ST_RX && rx_in.valid && cnt_q < BUF_MAX) begin
      buf_q[cnt_q] <= rx_in.data;
    end else if (st_q == ST_EVAL && respond && is_err) begin
      buf_q[1] <= exc_w;
      buf_q[2] <= sub_w;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      len_q <= 4'h0;
    end else if (st_q == ST_EVAL) begin
      len_q <= is_err ? LEN_ERR : LEN_ECHO;
    end
  end

  // run word written only on success
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_command_word_q <= RUN_RESET;
    end else if (st_q == ST_EVAL && respond && !is_err) begin
      run_command_word_q <= word_w;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_link_error_code_q <= SUB_NONE;
    end else if (st_q == ST_EVAL && respond && is_err) begin
      last_link_error_code_q <= sub_w;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || st_q != ST_TX) begin
      idx_q <= 4'h0;
      tx_valid_q <= 1'b0;
      tx_q <= '0;
    end else if (tx_step) begin
      tx_valid_q <= tx_more;
      if (tx_more) begin
        tx_q.data <= buf_q[idx_q];
        tx_q.last <= (idx_q + 4'h1) == len_q;
        idx_q <= idx_q + 4'h1;
      end
    end
  end

  wire logic eval_multi = st_q == ST_EVAL && for_us && is_multi;
  wire logic eval_good = st_q == ST_EVAL && respond && !is_err;

  AST_BCAST: assert property (@(posedge ref_clk) disable iff (rst)
    (st_q == ST_EVAL && q_addr == BCAST_ADDR)
      |=> st_q == ST_RX && !tx_valid_q && $stable(run_command_word_q))
    else $error("broadcast was answered");

  AST_START: assert property (@(posedge ref_clk) disable iff (rst)
    (eval_multi && q_start >= COIL_LIMIT)
      |=> last_link_error_code_q == SUB_ADDR)
    else $error("start address error not reported");

  AST_BYTECNT: assert property (@(posedge ref_clk) disable iff (rst)
    (eval_multi && !addr_bad && !link_no_write && q_bc == 8'h00)
      |=> last_link_error_code_q == SUB_DATA)
    else $error("zero byte count not reported");

  AST_BIGBC: assert property (@(posedge ref_clk) disable iff (rst)
    (eval_multi && !addr_bad && !link_no_write && q_bc > BC_MAX)
      |=> last_link_error_code_q == SUB_DATA)
    else $error("oversized byte count not reported");

  AST_QTY: assert property (@(posedge ref_clk) disable iff (rst)
    (eval_multi && q_start < COIL_LIMIT && q_qty > QTY_MAX)
      |=> last_link_error_code_q == SUB_ADDR && len_q == LEN_ERR)
    else $error("coil count error not reported");

  AST_RANGE: assert property (@(posedge ref_clk) disable iff (rst)
    (eval_multi && q_start < COIL_LIMIT && q_qty != 16'h0000 &&
      q_qty <= QTY_MAX) |-> sub_w != SUB_ADDR)
    else $error("coil overrun flagged as bad address");

  AST_WIDE: assert property (@(posedge ref_clk) disable iff (rst)
    (eval_multi && !addr_bad && !link_no_write && q_qty >= QTY_WIDE &&
      q_bc < BC_MAX)
      |=> last_link_error_code_q == SUB_DATA && len_q == LEN_ERR)
    else $error("wide count with short data not reported");

  AST_NARROW: assert property (@(posedge ref_clk) disable iff (rst)
    (eval_multi && !addr_bad && !link_no_write && !run_locked &&
      q_qty < QTY_WIDE && q_bc == BC_MAX && !len_bad)
      |=> len_q == LEN_ECHO)
    else $error("narrow count with two data bytes refused");

  AST_FIRSTBIT: assert property (@(posedge ref_clk) disable iff (rst)
    (eval_good && !RUN_RSVD[q_start[3:0]])
      |=> run_command_word_q[$past(q_start[3:0])] == $past(buf_q[7][0]))
    else $error("first data bit not placed at start coil");

  AST_RSVD: assert property (@(posedge ref_clk) disable iff (rst)
    (run_command_word_q & RUN_RSVD) == 16'h0000)
    else $error("reserved run bit set");

  AST_ECHO: assert property (@(posedge ref_clk) disable iff (rst)
    (st_q == ST_EVAL && respond && !is_err)
      |=> len_q == LEN_ECHO && buf_q[1] == FC_FORCE_MULTI)
    else $error("good write not echoed");

  AST_ECHOFC: assert property (@(posedge ref_clk) disable iff (rst)
    (tx_valid_q && idx_q == 4'h2 && len_q == LEN_ECHO)
      |-> tx_q.data == FC_FORCE_MULTI)
    else $error("echo function byte wrong");

  AST_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    (tx_valid_q && !tx_ready) |=> tx_valid_q && $stable(tx_q))
    else $error("answer byte dropped before it was taken");

  AST_NOEXEC: assert property (@(posedge ref_clk) disable iff (rst)
    (st_q == ST_EVAL && is_err) |=> $stable(run_command_word_q))
    else $error("improper query executed");

  AST_STATION: assert property (@(posedge ref_clk) disable iff (rst)
    (tx_valid_q && idx_q == 4'h1) |-> tx_q.data == own_addr)
    else $error("answer station address wrong");

  AST_EXCFN: assert property (@(posedge ref_clk) disable iff (rst)
    (st_q == ST_EVAL && respond && is_err)
      |=> buf_q[1] == (($past(q_fc) > EXC_FLAG) ? $past(q_fc) :
        ($past(q_fc) ^ EXC_FLAG)) && buf_q[0] == $past(q_addr))
    else $error("exception function byte wrong");

  AST_EXCTX: assert property (@(posedge ref_clk) disable iff (rst)
    (tx_valid_q && idx_q == 4'h2 && len_q == LEN_ERR)
      |-> tx_q.data[7] || tx_q.data == 8'h00)
    else $error("exception function byte lacks the error flag");

  AST_UNKFC: assert property (@(posedge ref_clk) disable iff (rst)
    (st_q == ST_EVAL && for_us && !fc_known)
      |=> last_link_error_code_q == SUB_FC && len_q == LEN_ERR)
    else $error("unsupported function not reported");

  AST_DIAG: assert property (@(posedge ref_clk) disable iff (rst)
    (st_q == ST_EVAL && for_us && q_fc == FC_DIAG && q_start != 16'h0000)
      |=> last_link_error_code_q == SUB_ADDR)
    else $error("bad diagnostics subfunction not reported");

  AST_NAK: assert property (@(posedge ref_clk) disable iff (rst)
    (eval_multi && !addr_bad && link_no_write)
      |=> last_link_error_code_q == SUB_NAK)
    else $error("missing write right not reported");

  AST_LOCK: assert property (@(posedge ref_clk) disable iff (rst)
    (eval_multi && !addr_bad && !link_no_write && !bc_bad && run_locked)
      |=> last_link_error_code_q == SUB_NAK)
    else $error("locked run word write not reported");

  AST_ORDER: assert property (@(posedge ref_clk) disable iff (rst)
    (eval_multi && !addr_bad && !link_no_write && bc_bad && run_locked)
      |=> last_link_error_code_q == SUB_DATA)
    else $error("data error not ahead of the run lock");

  AST_SUBTX: assert property (@(posedge ref_clk) disable iff (rst)
    (tx_valid_q && tx_q.last && len_q == LEN_ERR)
      |-> tx_q.data == last_link_error_code_q)
    else $error("sent subcode differs from the stored one");

  AST_GAP: assert property (@(posedge ref_clk) disable iff (rst)
    (st_q == ST_RX && cnt_q != 4'h0 && gap_q >= GAP_BITS) |=> st_q == ST_EVAL)
    else $error("frame not closed after a long gap");

  AST_KEEP: assert property (@(posedge ref_clk) disable iff (rst)
    (eval_good && q_start[3:0] != 4'h0)
      |=> run_command_word_q[0] == $past(run_command_word_q[0]))
    else $error("coil below the start address changed");

  AST_BADCRC: assert property (@(posedge ref_clk) disable iff (rst)
    (st_q == ST_EVAL && !crc_ok)
      |=> st_q == ST_RX && $stable(last_link_error_code_q))
    else $error("bad frame answered");
endmodule // cwr_responder

// File: design/cwr_pkg.sv
// shared constants and carriers for the coil write and exception responder
package cwr_pkg;
  localparam int BUF_DEPTH = 12;
  localparam logic [3:0] BUF_MAX = 4'hC;
  localparam logic [5:0] GAP_BITS = 6'h21;
  localparam logic [7:0] FC_READ_COIL = 8'h01;
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_FORCE_ONE = 8'h05;
  localparam logic [7:0] FC_PRESET_ONE = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_FORCE_MULTI = 8'h0F;
  localparam logic [7:0] FC_PRESET_MULTI = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] SUB_NONE = 8'h00;
  localparam logic [7:0] SUB_FC = 8'h01;
  localparam logic [7:0] SUB_ADDR = 8'h02;
  localparam logic [7:0] SUB_DATA = 8'h03;
  localparam logic [7:0] SUB_NAK = 8'h07;
  localparam logic [15:0] COIL_LIMIT = 16'h0010;
  localparam logic [15:0] QTY_MAX = 16'h0010;
  localparam logic [15:0] QTY_WIDE = 16'h0009;
  localparam logic [7:0] BC_MAX = 8'h02;
  localparam logic [7:0] FRAME_FIXED = 8'h09;
  localparam logic [3:0] MIN_FRAME = 4'h4;
  localparam logic [3:0] LEN_ERR = 4'h3;
  localparam logic [3:0] LEN_ECHO = 4'h6;
  localparam logic [15:0] RUN_RSVD = 16'h1800;
  localparam logic [15:0] RUN_RESET = 16'h0000;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cwr_rx_s;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } cwr_tx_s;

  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_EVAL = 2'b01,
    ST_TX = 2'b10
  } cwr_state_e;
endpackage

// File: tb/cwr_host_model.sv
// host master model: sends queries, makes bit ticks, takes answers
`timescale 1ns/1ns
module cwr_host_model (
  input wire logic ref_clk,
  input wire logic slow,
  output cwr_pkg::cwr_rx_s rx_out,
  output logic bit_tick,
  output logic tx_ready
);
  import cwr_pkg::*;

  logic ph_q;
  initial begin
    rx_out = '0;
    bit_tick = 1'b0;
    tx_ready = 1'b1;
    ph_q = 1'b0;
  end
  // one bit time every two cycles; answers taken promptly or with stalls
  always @(posedge ref_clk) begin
    ph_q <= ~ph_q;
    bit_tick <= ph_q;
    tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
  end
  // bytes in order, gaps far below 33 bits
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge ref_clk);
      rx_out <= '{1'b1, b[i]};
      @(posedge ref_clk);
      rx_out <= '{1'b0, ~b[i]};
      repeat (6) @(posedge ref_clk);
    end
  endtask
endmodule // cwr_host_model

// File: tb/cwr_responder_tb.sv
// self-checking bench for the coil write and exception responder
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin \
  err_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module cwr_responder_tb;
  import cwr_pkg::*;
  logic ref_clk, rst, crc_ok, link_no_write, run_locked, slow, tx_ready;
  logic bit_tick, tx_valid_q;
  logic [7:0] own_addr, last_link_error_code_q, code_exp, bcr;
  logic [7:0] qb[$];
  logic [15:0] run_command_word_q, run_exp;
  cwr_rx_s rx_in;
  cwr_tx_s tx_q, t;
  cwr_tx_s exp_q[$];
  int err_count, checks, cyc, n, nd;
  cwr_responder dut (.ref_clk(ref_clk), .rst(rst), .rx_in(rx_in),
    .bit_tick(bit_tick), .crc_ok(crc_ok), .own_addr(own_addr),
    .link_no_write(link_no_write), .run_locked(run_locked),
    .tx_ready(tx_ready), .tx_q(tx_q), .tx_valid_q(tx_valid_q),
    .run_command_word_q(run_command_word_q),
    .last_link_error_code_q(last_link_error_code_q));
  cwr_host_model host (.ref_clk(ref_clk), .slow(slow), .rx_out(rx_in),
    .bit_tick(bit_tick), .tx_ready(tx_ready));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // answer watcher with cycle ceiling
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      results();
    end else if ((tx_valid_q & tx_ready) === 1'b1) begin
      if (exp_q.size() == 0) `CHK("unexpected answer", 1'b0, 1'b1)
      else begin
        t = exp_q.pop_front();
        `CHK("answer byte", t, tx_q)
      end
    end
  end
  task automatic flags(input logic c, input logic l, input logic k);
    @(posedge ref_clk);
    crc_ok <= c;
    link_no_write <= l;
    run_locked <= k;
    @(posedge ref_clk);
  endtask
  task automatic go(input logic [7:0] b[$], input logic [7:0] sc,
                    input logic ans, input logic [15:0] nw);
    logic [7:0] f;
    f = b[1];
    if (ans && crc_ok && b[0] == own_addr) begin
      if (sc != SUB_NONE) begin
        exp_q.push_back('{b[0], 1'b0});
        exp_q.push_back('{(f > EXC_FLAG) ? f : f + EXC_FLAG, 1'b0});
        exp_q.push_back('{sc, 1'b1});
        code_exp = sc;
      end else begin
        for (int i = 0; i < 6; i++) exp_q.push_back('{b[i], i == 5});
        run_exp = nw;
      end
    end
    b.push_back(8'($urandom()));
    b.push_back(8'($urandom()));
    host.send(b);
    repeat (90) @(posedge ref_clk);
    for (int k = 0; k < 400 && (exp_q.size() > 0 || tx_valid_q); k++)
      @(posedge ref_clk);
    `CHK("run word", run_exp, run_command_word_q)
    `CHK("error code", code_exp, last_link_error_code_q)
    `CHK("answers left", 0, exp_q.size())
    exp_q.delete();
    n++;
    $display("test %0d done", n);
  endtask
  task automatic q15(input logic [7:0] a, input logic [15:0] st, qty,
                     input logic [7:0] bc, input int nd);
    logic [7:0] d[$];
    logic [7:0] b[$];
    logic [7:0] sc;
    logic [15:0] nw;
    for (int i = 0; i < nd; i++) d.push_back(8'($urandom()));
    sc = SUB_NONE;
    nw = run_exp;
    if (st >= COIL_LIMIT || qty == 16'h0000 || qty > QTY_MAX) sc = SUB_ADDR;
    else if (link_no_write) sc = SUB_NAK;
    else if (bc == 8'h00 || bc > BC_MAX || (qty >= QTY_WIDE && bc < BC_MAX)
             || nd != int'(bc)) sc = SUB_DATA;
    else if (run_locked) sc = SUB_NAK;
    for (int i = 0; i < 16; i++)
      if (sc == SUB_NONE && i < int'(qty) && int'(st) + i < 16)
        nw[int'(st) + i] = d[i / 8][i % 8];
    b = {a, FC_FORCE_MULTI, st[15:8], st[7:0], qty[15:8], qty[7:0], bc};
    b = {b, d};
    go(b, sc, 1'b1, nw & ~RUN_RSVD);
  endtask
  initial begin
    rst = 1'b1;
    crc_ok = 1'b1;
    link_no_write = 1'b0;
    run_locked = 1'b0;
    slow = 1'b0;
    own_addr = 8'h05;
    run_exp = RUN_RESET;
    code_exp = SUB_NONE;
    void'($urandom(16187));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    q15(8'h05, 16'h0002, 16'h0009, 8'h02, 2);
    q15(8'h05, 16'h0008, 16'h0008, 8'h01, 1);
    q15(8'h05, 16'h000F, 16'h0010, 8'h02, 2);
    q15(8'h05, 16'h0000, 16'h0009, 8'h01, 1);
    q15(8'h05, 16'h0003, 16'h0008, 8'h02, 2);
    q15(8'h05, 16'h0001, 16'h0011, 8'h02, 2);
    q15(8'h05, 16'h0001, 16'h0000, 8'h01, 1);
    q15(8'h05, 16'h0010, 16'h0001, 8'h01, 1);
    q15(8'h00, 16'h0000, 16'h0004, 8'h01, 1);
    q15(8'h06, 16'h0000, 16'h0004, 8'h01, 1);
    flags(1'b0, 1'b0, 1'b0);
    q15(8'h05, 16'h0000, 16'h0004, 8'h01, 1);
    flags(1'b1, 1'b1, 1'b1);
    q15(8'h05, 16'h0000, 16'h0004, 8'h03, 3);
    flags(1'b1, 1'b0, 1'b1);
    q15(8'h05, 16'h0000, 16'h0004, 8'h03, 3);
    q15(8'h05, 16'h0000, 16'h0004, 8'h01, 1);
    flags(1'b1, 1'b0, 1'b0);
    qb = {8'h05, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01};
    go(qb, SUB_FC, 1'b1, run_exp);
    qb = {8'h05, 8'hC1, 8'h00, 8'h00, 8'h00, 8'h01};
    go(qb, SUB_FC, 1'b1, run_exp);
    qb = {8'h05, FC_DIAG, 8'h00, 8'h01, 8'h12, 8'h34};
    go(qb, SUB_ADDR, 1'b1, run_exp);
    qb = {8'h05, FC_DIAG, 8'h00, 8'h00, 8'h12, 8'h34};
    go(qb, SUB_NONE, 1'b0, run_exp);
    qb = {8'h05, FC_READ_HOLD, 8'h00, 8'h00, 8'h00, 8'h01};
    go(qb, SUB_NONE, 1'b0, run_exp);
    qb = {8'h05, 8'h80, 8'h00, 8'h00, 8'h00, 8'h01};
    go(qb, SUB_FC, 1'b1, run_exp);
    qb = {8'h05, FC_PRESET_MULTI, 8'h00, 8'h00, 8'h00, 8'h01};
    go(qb, SUB_NONE, 1'b0, run_exp);
    slow <= 1'b1;
    repeat (24) begin
      flags(1'b1, $urandom_range(3) == 0, $urandom_range(3) == 0);
      bcr = 8'($urandom_range(3));
      nd = ($urandom_range(3) == 0 && bcr == 8'h02) ? 1 : int'(bcr);
      q15(8'h05, 16'($urandom_range(17)), 16'($urandom_range(18)), bcr, nd);
    end
    results();
  end
endmodule // cwr_responder_tb
